// *** core/twx_cfg.svh ***
// constants for the table-write, skip and xor execution block
`ifndef TWX_CFG_SVH
`define TWX_CFG_SVH
// opcode patterns (16-bit instruction words)
`define TWX_OP_TBLWR_HI  14'h0003
`define TWX_OP_XORLIT_HI 8'h0a
`define TWX_OP_XORF_HI   6'h06
`define TWX_OP_TSTZ_HI   7'h33
// field positions
`define TWX_DEST_BIT     9
`define TWX_ACC_BIT      8
// pointer mode codes
`define TWX_MODE_NONE    2'h0
`define TWX_MODE_POSTINC 2'h1
`define TWX_MODE_POSTDEC 2'h2
`define TWX_MODE_PREINC  2'h3
// reset values and widths
`define TWX_PTR_W        21
`define TWX_PTR_RST      21'h000000
`define TWX_BYTE_RST     8'h00
`endif

// *** core/twx_pkg.sv ***
// types for the table-write, skip and xor execution block
package twx_pkg;
  // execution state, one-hot
  typedef enum logic [1:0] {
    TWX_ST_EXEC  = 2'b01, // decode and run an instruction
    TWX_ST_SLOT2 = 2'b10  // second cycle: table write or squashed slot
  } twx_state_t;
  // decoded operation class
  typedef enum logic [2:0] {
    TWX_K_OTHER = 3'h0,
    TWX_K_TBLWR = 3'h1,
    TWX_K_TSTZ  = 3'h2,
    TWX_K_XORL  = 3'h3,
    TWX_K_XORF  = 3'h4
  } twx_kind_t;
endpackage

// *** core/twx_alu.sv ***
// xor datapath with negative and zero flag generation
module twx_alu (
  input  wire logic [7:0] w_i,      // working register value
  input  wire logic [7:0] opnd_i,   // literal or file operand
  output logic      [7:0] res_o,    // exclusive-or result
  output logic            neg_o,    // result bit 7
  output logic            zero_o    // result equals zero
);
  // ***********************************************
  // combinational xor
  // ***********************************************
  always_comb begin
    res_o  = w_i ^ opnd_i;
    neg_o  = res_o[7];
    zero_o = (res_o == 8'h00);
  end
endmodule // twx_alu

// *** core/twx_exec.sv ***
// execution unit for table write, test-skip-zero and xor instructions
// Notes on behaviour
// - table write no-update: latch to holding, pointer kept
// - post-increment: write holding, then pointer plus one
// - pointer is 21 bits, spanning 2 Mbyte
// - pointer counts bytes; each step is one
// - zero file register squashes next instruction
// - xor immediate into working reg, N Z
// - xor file, dest bit picks target, N Z
`include "twx_cfg.svh"
module twx_exec
  import twx_pkg::*;
#(
  parameter int PTR_W = `TWX_PTR_W  // table pointer width
) (
  input  wire logic             ref_clk_i,    // core instruction clock
  input  wire logic             arst_n_i,     // async reset, active low
  input  wire logic             instr_vld_i,  // fetched word is valid
  input  wire logic [15:0]      instr_i,      // fetched instruction word
  input  wire logic [7:0]       file_rd_i,    // data of register 'f'
  input  wire logic [7:0]       table_latch_i,// table latch byte
  output logic      [7:0]       w_o,          // working register
  output logic                  neg_o,        // negative flag
  output logic                  zero_o,       // zero flag
  output logic      [PTR_W-1:0] table_pointer_o, // byte pointer
  output logic                  hold_we_o,    // holding write strobe
  output logic      [2:0]       hold_sel_o,   // holding register index
  output logic      [7:0]       hold_data_o,  // holding write data
  output logic                  file_we_o,    // file write strobe
  output logic      [7:0]       file_addr_o,  // file write address
  output logic                  file_acc_o,   // access-bank select bit
  output logic      [7:0]       file_wd_o,    // file write data
  output logic                  squash_o      // slot discarded as nop
);
  // ***********************************************
  // decode helpers
  // ***********************************************
  function automatic twx_kind_t decode_kind(input logic [15:0] ins);
    twx_kind_t k;
    k = TWX_K_OTHER;
    if (ins[15:2] == `TWX_OP_TBLWR_HI)      k = TWX_K_TBLWR;
    else if (ins[15:8] == `TWX_OP_XORLIT_HI) k = TWX_K_XORL;
    else if (ins[15:10] == `TWX_OP_XORF_HI)  k = TWX_K_XORF;
    else if (ins[15:9] == `TWX_OP_TSTZ_HI)   k = TWX_K_TSTZ;
    return k;
  endfunction

  // one-byte pointer step, sign by direction
  function automatic logic [PTR_W-1:0] ptr_step(
    input logic [PTR_W-1:0] p, input logic down);
    ptr_step = down ? p - PTR_W'(1) : p + PTR_W'(1);
  endfunction

  twx_kind_t        kind;          // class of the fetched word
  logic [7:0]       alu_opnd;      // operand to the xor unit
  logic [7:0]       alu_res;       // xor result
  logic             alu_neg;       // xor negative
  logic             alu_zero;      // xor zero

  twx_state_t       state_reg,  state_next;   // sequencer state
  logic [1:0]       mode_reg,   mode_next;    // saved pointer mode
  logic [PTR_W-1:0] ptr_reg,    ptr_next;     // table pointer
  logic [7:0]       w_reg,      w_next;       // working register
  logic             neg_reg,    neg_next;     // negative flag
  logic             zero_reg,   zero_next;    // zero flag
  logic             hwe_reg,    hwe_next;     // holding write strobe
  logic [2:0]       hsel_reg,   hsel_next;    // holding index
  logic [7:0]       hdat_reg,   hdat_next;    // holding data
  logic             fwe_reg,    fwe_next;     // file write strobe
  logic [7:0]       fadr_reg,   fadr_next;    // file address
  logic             facc_reg,   facc_next;    // access select
  logic [7:0]       fwd_reg,    fwd_next;     // file write data
  logic             sq_reg,     sq_next;      // squash marker

  assign kind     = decode_kind(instr_i);
  assign alu_opnd = (kind == TWX_K_XORL) ? instr_i[7:0] : file_rd_i;

  twx_alu u_alu (
    .w_i    (w_reg),
    .opnd_i (alu_opnd),
    .res_o  (alu_res),
    .neg_o  (alu_neg),
    .zero_o (alu_zero)
  );

  // ***********************************************
  // next-state logic
  // ***********************************************
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    ptr_next   = ptr_reg;
    w_next     = w_reg;
    neg_next   = neg_reg;
    zero_next  = zero_reg;
    hwe_next   = 1'b0;
    hsel_next  = hsel_reg;
    hdat_next  = hdat_reg;
    fwe_next   = 1'b0;
    fadr_next  = fadr_reg;
    facc_next  = facc_reg;
    fwd_next   = fwd_reg;
    sq_next    = 1'b0;
    case (state_reg)
      TWX_ST_EXEC: begin
        if (instr_vld_i) begin
          case (kind)
            TWX_K_TBLWR: begin
              // first cycle latches the mode field and enters the second slot
              mode_next  = instr_i[1:0];
              state_next = TWX_ST_SLOT2;
              // pre-increment moves pointer before the write
              if (instr_i[1:0] == `TWX_MODE_PREINC) begin
                ptr_next = ptr_step(ptr_reg, 1'b0);
              end
            end
            TWX_K_TSTZ: begin
              // zero operand discards the already-fetched word
              if (file_rd_i == 8'h00) begin
                state_next = TWX_ST_SLOT2;
                sq_next    = 1'b1;
              end
            end
            TWX_K_XORL: begin
              w_next    = alu_res;
              neg_next  = alu_neg;
              zero_next = alu_zero;
            end
            TWX_K_XORF: begin
              neg_next  = alu_neg;
              zero_next = alu_zero;
              if (instr_i[`TWX_DEST_BIT]) begin
                // destination set: back to file register
                fwe_next  = 1'b1;
                fadr_next = instr_i[7:0];
                facc_next = instr_i[`TWX_ACC_BIT];
                fwd_next  = alu_res;
              end else begin
                w_next = alu_res;
              end
            end
            default: begin
              // other instructions belong to other units
            end
          endcase
        end
      end
      TWX_ST_SLOT2: begin
        state_next = TWX_ST_EXEC;
        if (!sq_reg) begin
          // holding write lands in the second cycle
          hwe_next  = 1'b1;
          hsel_next = ptr_reg[2:0];
          hdat_next = table_latch_i;
          case (mode_reg)
            `TWX_MODE_POSTINC: ptr_next = ptr_step(ptr_reg, 1'b0);
            `TWX_MODE_POSTDEC: ptr_next = ptr_step(ptr_reg, 1'b1);
            default:           ptr_next = ptr_reg;
          endcase
        end
      end
      default: begin
        state_next = TWX_ST_EXEC;
      end
    endcase
  end

  // ***********************************************
  // state registers
  // ***********************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= TWX_ST_EXEC;
      mode_reg  <= `TWX_MODE_NONE;
      ptr_reg   <= PTR_W'(`TWX_PTR_RST);
      w_reg     <= `TWX_BYTE_RST;
      neg_reg   <= 1'b0;
      zero_reg  <= 1'b0;
      hwe_reg   <= 1'b0;
      hsel_reg  <= 3'h0;
      hdat_reg  <= `TWX_BYTE_RST;
      fwe_reg   <= 1'b0;
      fadr_reg  <= 8'h00;
      facc_reg  <= 1'b0;
      fwd_reg   <= `TWX_BYTE_RST;
      sq_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      ptr_reg   <= ptr_next;
      w_reg     <= w_next;
      neg_reg   <= neg_next;
      zero_reg  <= zero_next;
      hwe_reg   <= hwe_next;
      hsel_reg  <= hsel_next;
      hdat_reg  <= hdat_next;
      fwe_reg   <= fwe_next;
      fadr_reg  <= fadr_next;
      facc_reg  <= facc_next;
      fwd_reg   <= fwd_next;
      sq_reg    <= sq_next;
    end
  end

  assign w_o             = w_reg;
  assign neg_o           = neg_reg;
  assign zero_o          = zero_reg;
  assign table_pointer_o = ptr_reg;
  assign hold_we_o       = hwe_reg;
  assign hold_sel_o      = hsel_reg;
  assign hold_data_o     = hdat_reg;
  assign file_we_o       = fwe_reg;
  assign file_addr_o     = fadr_reg;
  assign file_acc_o      = facc_reg;
  assign file_wd_o       = fwd_reg;
  assign squash_o        = sq_reg;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_nomode_ptr_kept: assert property (
    (state_reg == TWX_ST_EXEC && instr_vld_i && kind == TWX_K_TBLWR
     && instr_i[1:0] == `TWX_MODE_NONE)
    |=> ##1 (ptr_reg == $past(ptr_reg, 2)))
    else $error("pointer moved in no-update table write");
  a_postinc_ptr: assert property (
    (state_reg == TWX_ST_EXEC && instr_vld_i && kind == TWX_K_TBLWR
     && instr_i[1:0] == `TWX_MODE_POSTINC)
    |=> ##1 (hold_we_o && ptr_reg == $past(ptr_reg, 2) + PTR_W'(1)))
    else $error("post-increment pointer wrong");
  a_hold_sel_low: assert property (
    hold_we_o |-> (hold_sel_o == $past(ptr_reg[2:0])))
    else $error("holding index not pointer low bits");
  a_skip_zero: assert property (
    (state_reg == TWX_ST_EXEC && instr_vld_i && kind == TWX_K_TSTZ
     && file_rd_i == 8'h00) |=> (squash_o && !hold_we_o) ##1 !squash_o)
    else $error("zero test did not squash one slot");
  a_xorl_result: assert property (
    (state_reg == TWX_ST_EXEC && instr_vld_i && kind == TWX_K_XORL)
    |=> (w_o == ($past(w_reg) ^ $past(instr_i[7:0]))
         && zero_o == (w_o == 8'h00) && neg_o == w_o[7]))
    else $error("xor immediate result or flags wrong");
  a_xorf_dest: assert property (
    (state_reg == TWX_ST_EXEC && instr_vld_i && kind == TWX_K_XORF)
    |=> (file_we_o == $past(instr_i[`TWX_DEST_BIT]))
        && (file_we_o
            ? (w_o == $past(w_reg)
               && file_wd_o == ($past(w_reg) ^ $past(file_rd_i)))
            : w_o == ($past(w_reg) ^ $past(file_rd_i))))
    else $error("xor file destination wrong");
  a_tblwr_second: assert property (
    (state_reg == TWX_ST_EXEC && instr_vld_i && kind == TWX_K_TBLWR)
    |=> !hold_we_o ##1 (hold_we_o && hold_data_o == $past(table_latch_i)))
    else $error("holding write not in second cycle");
  a_ptr_step_one: assert property (
    $changed(ptr_reg) |-> (ptr_reg == $past(ptr_reg) + PTR_W'(1)
                           || ptr_reg == $past(ptr_reg) - PTR_W'(1)))
    else $error("pointer moved by more than one byte");

  c_tblwr:  cover property (hold_we_o);
  c_skip:   cover property (squash_o);
  c_xorf:   cover property (file_we_o);
  c_preinc: cover property (state_reg == TWX_ST_EXEC && instr_vld_i
                            && kind == TWX_K_TBLWR && instr_i[1:0] == 2'h3);
endmodule // twx_exec

// *** bench/twx_exec_test.sv ***
// self-checking bench for the table-write, skip and xor execution unit
module twx_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals and instance
  // ****************************************
  logic        ref_clk_i;       // core instruction clock
  logic        arst_n_i;        // async reset, active low
  logic        instr_vld_i;     // fetched word valid
  logic [15:0] instr_i;         // fetched word
  logic [7:0]  file_rd_i;       // file register read data
  logic [7:0]  table_latch_i;   // table latch byte
  logic [7:0]  w_o;             // working register
  logic        neg_o;           // negative flag
  logic        zero_o;          // zero flag
  logic [20:0] table_pointer_o; // byte pointer
  logic        hold_we_o;       // holding write strobe
  logic [2:0]  hold_sel_o;      // holding index
  logic [7:0]  hold_data_o;     // holding data
  logic        file_we_o;       // file write strobe
  logic [7:0]  file_addr_o;     // file address
  logic        file_acc_o;      // access-bank bit
  logic [7:0]  file_wd_o;       // file write data
  logic        squash_o;        // slot discarded
  int          miscompares;     // mismatches seen
  int          total_checks;    // comparisons made
  logic [20:0] ptr_exp;         // expected pointer
  twx_exec i_twx_exec (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .instr_vld_i(instr_vld_i), .instr_i(instr_i), .file_rd_i(file_rd_i),
    .table_latch_i(table_latch_i), .w_o(w_o), .neg_o(neg_o),
    .zero_o(zero_o), .table_pointer_o(table_pointer_o),
    .hold_we_o(hold_we_o), .hold_sel_o(hold_sel_o),
    .hold_data_o(hold_data_o), .file_we_o(file_we_o),
    .file_addr_o(file_addr_o), .file_acc_o(file_acc_o),
    .file_wd_o(file_wd_o), .squash_o(squash_o));
  // ****************************************
  // helpers
  // ****************************************
  // compare and count, four-state exact
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // present one word on the next edge, valid left high
  task automatic issue(input logic [15:0] w, input logic [7:0] f);
    @(posedge ref_clk_i);
    instr_vld_i <= 1'b1;
    instr_i     <= w;
    file_rd_i   <= f;
  endtask
  // drop valid on the next edge, then let outputs settle
  task automatic idle;
    @(posedge ref_clk_i);
    instr_vld_i <= 1'b0;
    #1;
  endtask
  // count extra edges until a strobe shows, bounded
  task automatic wait_for(input int s, output int n);
    n = 0;
    while (n < 4 && !(s == 0 ? hold_we_o === 1'b1 : s == 1 ?
           file_we_o === 1'b1 : squash_o === 1'b1)) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // back-to-back literal xor, flags for negative and zero results
  task automatic t_xor_immediate_op;
    chk({w_o, table_pointer_o, hold_we_o, squash_o}, 32'h0, "reset");
    issue(16'h0ab5, 8'h00);
    issue(16'h0aaf, 8'h00);
    #1 chk({w_o, neg_o, zero_o}, {8'hb5, 2'b10}, "xor_immediate_op b5");
    issue(16'h0a1a, 8'h00);
    #1 chk({w_o, neg_o, zero_o}, {8'h1a, 2'b00}, "xor_immediate_op af");
    idle();
    chk({w_o, neg_o, zero_o}, {8'h00, 2'b01}, "xor_immediate_op 1a");
    chk(file_we_o, 1'b0, "xor_immediate_op no file write");
    $display("test xor_immediate_op done");
  endtask
  // file xor to each destination
  task automatic t_xor_file_op;
    int n;
    issue(16'h1820, 8'h0f);
    idle();
    chk({w_o, neg_o, zero_o, file_we_o}, {8'h0f, 3'b000}, "xor_file_op w");
    issue(16'h1b40, 8'hf0);
    idle();
    wait_for(1, n);
    chk(n, 0, "xor_file_op strobe time");
    chk({file_addr_o, file_acc_o, file_wd_o}, {8'h40, 1'b1, 8'hff},
        "xor_file_op f");
    chk({w_o, neg_o, zero_o}, {8'h0f, 2'b10}, "xor_file_op w kept");
    issue(16'h1a41, 8'h0f);
    idle();
    chk({file_we_o, file_acc_o, file_wd_o, zero_o}, {2'b10, 8'h00, 1'b1},
        "xor_file_op zero");
    $display("test xor_file_op done");
  endtask
  // one table write; busy puts a word into the second slot
  task automatic tbl(input logic [1:0] m, input logic busy);
    int         n;
    logic [2:0] sel;
    logic [7:0] lat;
    lat = {m, busy, 5'h0b} ^ ptr_exp[7:0];
    if (m == 2'h3) ptr_exp = ptr_exp + 21'h1;
    sel = ptr_exp[2:0];
    if (m == 2'h1) ptr_exp = ptr_exp + 21'h1;
    if (m == 2'h2) ptr_exp = ptr_exp - 21'h1;
    issue({14'h0003, m}, 8'h00);
    table_latch_i <= lat;
    if (busy) issue(16'h0a55, 8'h00);
    idle();
    wait_for(0, n);
    chk(n, busy ? 0 : 1, "table write slot");
    chk({hold_sel_o, hold_data_o}, {sel, lat}, "holding write");
    chk(table_pointer_o, ptr_exp, "pointer");
    chk(w_o, 8'h0f, "slot two ignored");
    @(posedge ref_clk_i);
    #1 chk(hold_we_o, 1'b0, "strobe one cycle");
  endtask
  // all four modes, with wrap at both pointer ends
  task automatic t_tbl;
    ptr_exp = 21'h0;
    tbl(2'h1, 1'b0);
    tbl(2'h3, 1'b1);
    tbl(2'h0, 1'b1);
    tbl(2'h2, 1'b0);
    tbl(2'h2, 1'b0);
    tbl(2'h2, 1'b0);
    tbl(2'h1, 1'b0);
    $display("test table write done");
  endtask
  // skip on zero squashes the following slot only
  task automatic t_skip;
    issue(16'h6610, 8'h01);
    idle();
    chk(squash_o, 1'b0, "no skip");
    @(posedge ref_clk_i);
    #1 chk(squash_o, 1'b0, "no skip late");
    issue(16'h6710, 8'h00);
    issue(16'h0aff, 8'h00);
    #1 chk(squash_o, 1'b1, "skip");
    idle();
    chk({w_o, squash_o}, {8'h0f, 1'b0}, "skipped word");
    issue(16'h0af0, 8'h00);
    idle();
    chk(w_o, 8'hff, "after skip");
    $display("test skip done");
  endtask
  // ****************************************
  // run control
  // ****************************************
  // prints counts and verdict, then ends the run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // free-running clock, 50 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // cuts a hang short at 400 cycles, far beyond the roughly 50 needed
  initial begin
    #20000;
    miscompares++;
    $display("CHECK FAILED %0t timeout", $time);
    summarize();
  end
  // main sequence
  initial begin
    miscompares = 0;
    total_checks = 0;
    arst_n_i = 1'b0;
    instr_vld_i = 1'b0;
    instr_i = 16'h0000;
    file_rd_i = 8'h00;
    table_latch_i = 8'h00;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_xor_immediate_op();
    t_xor_file_op();
    t_tbl();
    t_skip();
    summarize();
  end
endmodule // twx_exec_test
